// ==== src/cpb_defines.vh ====
// Purpose: address map, field layout and reset values of the buffer/filter registers
// Assumes: word-aligned 32-bit registers, 8-bit data in bits 7:0
// Notes: definitions only
`ifndef CPB_DEFINES_VH
`define CPB_DEFINES_VH

// regions, selected by haddr[11:8]
`define CPB_REGION_BUF_LO   4'h0
`define CPB_REGION_BUF_HI   4'h1
`define CPB_REGION_FILT     4'h2
`define CPB_REGION_CTRL     4'h3

// per-buffer word index within a 0x40 slot
`define CPB_BUF_STD_HIGH    4'h0
`define CPB_BUF_STD_LOW     4'h1
`define CPB_BUF_EXT_HIGH    4'h2
`define CPB_BUF_EXT_LOW     4'h3
`define CPB_BUF_LENGTH      4'h4
`define CPB_BUF_DATA0       4'h5
`define CPB_BUF_LAST        4'hc
`define CPB_BUF_WORDS       13

// per-filter word index within a 0x10 slot
`define CPB_FLT_STD_HIGH    2'h0
`define CPB_FLT_STD_LOW     2'h1
`define CPB_FLT_EXT_HIGH    2'h2
`define CPB_FLT_EXT_LOW     2'h3

// control words, offsets within region 3
`define CPB_CTRL_DIRECTION  8'h00
`define CPB_CTRL_MODE       8'h04
`define CPB_CTRL_FULL       8'h08
`define CPB_CTRL_SEND       8'h0c
`define CPB_CTRL_ACTIVE     8'h10

// field layout
`define CPB_DIR_LSB         2
`define CPB_DIR_MASK        8'hfc
`define CPB_STD_LOW_MASK    8'heb
`define CPB_EXT_FRAME_BIT   3
`define CPB_FLT_EXT_BIT     3
`define CPB_RTR_BIT         6
`define CPB_LEN_MASK        8'h0f

// reset values, mode codes and legacy filter count
`define CPB_DIR_RESET       6'h00
`define CPB_MODE_RESET      2'h0
`define CPB_MODE_ONE        2'h1
`define CPB_MODE_TWO        2'h2
`define CPB_LEGACY_FILTERS  6

`endif

// ==== src/cpb_buffer_filter_regs.v ====
// Purpose: register set of six programmable tx/rx message buffers and sixteen filters
// Assumes: AHB-Lite slave on hclk, receive and transmit engines on the same clock
// Notes: writes take no wait state, reads take one wait state
//
// Functional notes
// - direction bits 7:2 select transmit (1) or receive (0); bits 1:0 read zero
// - buffer id, data and length registers exist only in modes 1 and 2
// - receive buffers are read-only; transmit buffers are read/write
// - each buffer keeps extended id bits 15:8 and 7:0 in two bytes
// - each buffer has eight full payload byte registers, 0 to 7
// - length code 0000..1000 means 0..8 bytes; 1001..1111 reserved
// - receive length register bit 6 shows a received remote request
// - receive length register bits 7, 5, 4 read zero
// - transmit length register bit 6 sets the outgoing remote request bit
// - transmit length register bits 7, 5, 4 read zero
// - sixteen filters; filters 6 to 15 exist only in modes 1 and 2
// - filter high byte and low bits 7:5 hold standard or extended id bits
// - filter low bits 1:0 hold id bits 17:16; another byte holds 15:8
// - filter low bit 3 accepts only extended frames; bits 4 and 2 read zero
// - buffer extended-frame bit chooses 11-bit or 29-bit identifier
// - buffer is read-only while its send request is pending or sending
// - a full receive buffer takes no new frame until software clears it
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "cpb_defines.vh"

module cpb_buffer_filter_regs #(
    parameter NUM_BUF = 6,
    parameter NUM_FLT = 16
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        rx_load,
    input  wire [2:0]  rx_buf_sel,
    input  wire [7:0]  rx_std_id_high,
    input  wire [7:0]  rx_std_id_low,
    input  wire [7:0]  rx_ext_id_high,
    input  wire [7:0]  rx_ext_id_low,
    input  wire [3:0]  rx_length_code,
    input  wire        rx_remote_request,
    input  wire [63:0] rx_payload,
    output wire [5:0]  rx_buf_open,
    input  wire [5:0]  tx_active,
    input  wire [5:0]  tx_done,
    input  wire [2:0]  tx_rd_buf,
    input  wire [3:0]  tx_rd_idx,
    output reg  [7:0]  tx_rd_data,
    output wire [5:0]  send_request,
    output wire [5:0]  send_remote_request,
    output wire [5:0]  buffer_extended_frame,
    output wire [15:0] filter_extended_only,
    output wire        mode_enhanced
);

    reg  [7:0] bmem [0:NUM_BUF*`CPB_BUF_WORDS-1];
    reg  [7:0] fmem [0:NUM_FLT*4-1];
    reg  [5:0] buffer_direction_bits;
    reg  [1:0] op_mode;
    reg  [5:0] buffer_full_flag;
    reg  [5:0] send_req;
    reg        dph_wr;
    reg        dph_rd;
    reg        rd_done;
    reg [11:0] dph_addr;
    reg  [7:0] rd_byte;
    reg [31:0] rd_word;
    reg  [5:0] clr_full;
    reg  [5:0] set_send;
    integer    i;
    integer    j;

    wire       take = hsel & htrans[1] & hready;
    wire [3:0] region = dph_addr[11:8];
    wire [3:0] b_idx = {1'b0, dph_addr[8:6]};
    wire [3:0] b_word = dph_addr[5:2];
    wire [3:0] f_idx = dph_addr[7:4];
    wire [1:0] f_word = dph_addr[3:2];
    wire [7:0] c_off = dph_addr[7:0];
    wire [7:0] wbyte = hwdata[7:0];

    // buffer slot address decode for bus accesses; the transmit read port checks its own range
    function buf_hit;
        input [11:0] a;
        begin
            buf_hit = (a[11:9] == 3'h0) && (a[8:6] < NUM_BUF)
                      && (a[5:2] <= `CPB_BUF_LAST);
        end
    endfunction

    function [6:0] buf_ptr;
        input [2:0] b;
        input [3:0] w;
        begin
            // 13 * b + w built from shifts so no bits are dropped
            buf_ptr = {1'b0, b, 3'b000} + {2'b00, b, 2'b00} + {4'b0000, b}
                      + {3'b000, w};
        end
    endfunction

    // mode 3 is treated like legacy: nothing optional appears
    // enhanced gate
    assign mode_enhanced = (op_mode == `CPB_MODE_ONE) || (op_mode == `CPB_MODE_TWO);

    wire       is_buf = buf_hit(dph_addr);
    wire [6:0] bptr = buf_ptr(dph_addr[8:6], b_word);
    wire       is_flt = (region == `CPB_REGION_FILT)
                        && (mode_enhanced || f_idx < `CPB_LEGACY_FILTERS);
    wire [5:0] fptr = {f_idx, f_word};
    wire       is_ctrl = (region == `CPB_REGION_CTRL);

    wire buf_writable = mode_enhanced && buffer_direction_bits[b_idx[2:0]]
                        && !send_req[b_idx[2:0]] && !tx_active[b_idx[2:0]];

    assign rx_buf_open = mode_enhanced ? (~buffer_direction_bits & ~buffer_full_flag)
                                       : 6'h00;
    wire rx_take = rx_load && (rx_buf_sel < NUM_BUF) && rx_buf_open[rx_buf_sel];

    assign hreadyout = !(dph_rd && !rd_done);
    assign hresp = 1'b0;
    assign send_request = send_req;

    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g = g + 1) begin : g_buf
            assign send_remote_request[g] =
                bmem[g*`CPB_BUF_WORDS+`CPB_BUF_LENGTH][`CPB_RTR_BIT];
            assign buffer_extended_frame[g] =
                bmem[g*`CPB_BUF_WORDS+`CPB_BUF_STD_LOW][`CPB_EXT_FRAME_BIT];
        end
        for (g = 0; g < NUM_FLT; g = g + 1) begin : g_flt
            assign filter_extended_only[g] = fmem[g*4+1][`CPB_FLT_EXT_BIT];
        end
    endgenerate

    // bus read mux, evaluated in the wait cycle after all writes settled
    always @* begin
        rd_byte = 8'h00;
        rd_word = 32'h0000_0000;
        if (is_buf) begin
            if (mode_enhanced) begin
                if (b_word == `CPB_BUF_LENGTH) begin
                    rd_byte = bmem[bptr] & (`CPB_LEN_MASK | 8'h40);
                end else if (b_word == `CPB_BUF_STD_LOW) begin
                    rd_byte = bmem[bptr] & `CPB_STD_LOW_MASK;
                end else begin
                    rd_byte = bmem[bptr];
                end
            end
            rd_word = {24'h000000, rd_byte};
        end else if (is_flt) begin
            if (f_word == `CPB_FLT_STD_LOW) begin
                rd_byte = fmem[fptr] & `CPB_STD_LOW_MASK;
            end else begin
                rd_byte = fmem[fptr];
            end
            rd_word = {24'h000000, rd_byte};
        end else if (is_ctrl && c_off == `CPB_CTRL_DIRECTION) begin
            rd_word = {24'h000000, buffer_direction_bits, 2'b00};
        end else if (is_ctrl && c_off == `CPB_CTRL_MODE) begin
            rd_word = {30'h00000000, op_mode};
        end else if (is_ctrl && c_off == `CPB_CTRL_FULL) begin
            rd_word = {26'h0000000, buffer_full_flag};
        end else if (is_ctrl && c_off == `CPB_CTRL_SEND) begin
            rd_word = {26'h0000000, send_req};
        end else if (is_ctrl && c_off == `CPB_CTRL_ACTIVE) begin
            rd_word = {26'h0000000, tx_active};
        end
    end

    // write strobes for control words
    always @* begin
        clr_full = 6'h00;
        set_send = 6'h00;
        if (dph_wr && is_ctrl && c_off == `CPB_CTRL_FULL) begin
            clr_full = hwdata[5:0];
        end else if (dph_wr && is_ctrl && c_off == `CPB_CTRL_SEND) begin
            set_send = hwdata[5:0] & buffer_direction_bits
                       & {6{mode_enhanced}};
        end
    end

    // ahb address and data phase tracking
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr   <= 1'b0;
            dph_rd   <= 1'b0;
            rd_done  <= 1'b0;
            dph_addr <= 12'h000;
            hrdata   <= 32'h0000_0000;
        end else begin
            if (dph_rd && !rd_done) begin
                rd_done <= 1'b1;
                hrdata  <= rd_word;
            end
            if (hready) begin
                dph_wr  <= take && hwrite;
                dph_rd  <= take && !hwrite;
                rd_done <= 1'b0;
                if (take) begin
                    dph_addr <= haddr;
                end
            end
        end
    end

    // control state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buffer_direction_bits <= `CPB_DIR_RESET;
            op_mode               <= `CPB_MODE_RESET;
            buffer_full_flag      <= 6'h00;
            send_req              <= 6'h00;
        end else begin
            if (dph_wr && is_ctrl && c_off == `CPB_CTRL_DIRECTION) begin
                buffer_direction_bits <= wbyte[7:`CPB_DIR_LSB];
            end
            if (dph_wr && is_ctrl && c_off == `CPB_CTRL_MODE) begin
                op_mode <= hwdata[1:0];
            end
            // full set with the stored frame
            for (i = 0; i < NUM_BUF; i = i + 1) begin
                if (rx_take && rx_buf_sel == i) begin
                    buffer_full_flag[i] <= 1'b1;
                end else if (clr_full[i]) begin
                    buffer_full_flag[i] <= 1'b0;
                end
                // software set wins over a completion in the same cycle
                if (set_send[i]) begin
                    send_req[i] <= 1'b1;
                end else if (tx_done[i]) begin
                    send_req[i] <= 1'b0;
                end
            end
        end
    end

    // message storage; contents are undefined after reset, as on the bus
    always @(posedge hclk) begin
        if (rx_take) begin
            bmem[buf_ptr(rx_buf_sel, `CPB_BUF_STD_HIGH)] <= rx_std_id_high;
            bmem[buf_ptr(rx_buf_sel, `CPB_BUF_STD_LOW)]  <= rx_std_id_low;
            bmem[buf_ptr(rx_buf_sel, `CPB_BUF_EXT_HIGH)] <= rx_ext_id_high;
            bmem[buf_ptr(rx_buf_sel, `CPB_BUF_EXT_LOW)]  <= rx_ext_id_low;
            bmem[buf_ptr(rx_buf_sel, `CPB_BUF_LENGTH)] <=
                {1'b0, rx_remote_request, 2'b00, rx_length_code};
            for (j = 0; j < 8; j = j + 1) begin
                bmem[buf_ptr(rx_buf_sel, `CPB_BUF_DATA0 + j[3:0])] <=
                    rx_payload[j*8 +: 8];
            end
        end
        // only unlocked transmit buffers accept writes
        if (dph_wr && is_buf && buf_writable) begin
            if (b_word == `CPB_BUF_LENGTH) begin
                bmem[bptr] <= wbyte & (`CPB_LEN_MASK | 8'h40);
            end else if (b_word == `CPB_BUF_STD_LOW) begin
                bmem[bptr] <= wbyte & `CPB_STD_LOW_MASK;
            end else begin
                bmem[bptr] <= wbyte;
            end
        end
        // legacy mode hides filters 6 to 15
        if (dph_wr && is_flt) begin
            if (f_word == `CPB_FLT_STD_LOW) begin
                fmem[fptr] <= wbyte & `CPB_STD_LOW_MASK;
            end else begin
                fmem[fptr] <= wbyte;
            end
        end
    end

    // transmit engine read port, one cycle latency
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_rd_data <= 8'h00;
        end else if (tx_rd_buf < NUM_BUF && tx_rd_idx <= `CPB_BUF_LAST) begin
            tx_rd_data <= bmem[buf_ptr(tx_rd_buf, tx_rd_idx)];
        end else begin
            tx_rd_data <= 8'h00;
        end
    end

endmodule // cpb_buffer_filter_regs

// ==== tb/cpb_regs_sva.sv ====
// Purpose: port checker for the buffer/filter register block
// Assumes: one clock, reset active low
// Notes: bound at the foot of this file
`timescale 1ns/100ps
module cpb_regs_sva (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire        rx_load,
    input wire [2:0]  rx_buf_sel,
    input wire [5:0]  rx_buf_open,
    input wire [5:0]  tx_done,
    input wire [5:0]  send_request,
    input wire [5:0]  buffer_extended_frame,
    input wire [15:0] filter_extended_only,
    input wire        mode_enhanced
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire tk = hsel & htrans[1] & hready;
    wire wt = tk & hwrite;
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay)
        else $error("response not okay");
    property p_rd_wait; tk && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait wrong");
    property p_wr_ready; wt |=> hreadyout; endproperty
    a_wr_ready: assert property (p_wr_ready)
        else $error("write stalled");
    property p_open_mode; |rx_buf_open |-> mode_enhanced; endproperty
    a_open_mode: assert property (p_open_mode)
        else $error("buffer open in legacy mode");
    property p_load_close;
        rx_load && rx_buf_sel < 3'd6 && rx_buf_open[rx_buf_sel] |=> !rx_buf_open[$past(rx_buf_sel)];
    endproperty
    a_load_close: assert property (p_load_close)
        else $error("full buffer still open");
    property p_done_clear; |($past(send_request) & ~send_request) |-> |$past(tx_done); endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("send request dropped early");
    property p_filt_wr; !$stable(filter_extended_only) |-> $past(wt, 2); endproperty
    a_filt_wr: assert property (p_filt_wr)
        else $error("filter bit changed alone");
    property p_mode_wr; !$stable(mode_enhanced) |-> $past(wt, 2); endproperty
    a_mode_wr: assert property (p_mode_wr)
        else $error("mode changed alone");
    property p_ext_src;
        !$stable(buffer_extended_frame) |-> $past(wt, 2) || $past(rx_load);
    endproperty
    a_ext_src: assert property (p_ext_src)
        else $error("frame kind changed alone");
    c_rd: cover property (tk && !hwrite);
    c_load: cover property (rx_load && |rx_buf_open);
    c_done: cover property (|tx_done);
endmodule // cpb_regs_sva

bind cpb_buffer_filter_regs cpb_regs_sva u_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .rx_load, .rx_buf_sel, .rx_buf_open, .tx_done,
    .send_request, .buffer_extended_frame, .filter_extended_only, .mode_enhanced);

// ==== tb/cpb_can_engine.sv ====
// Purpose: receive and transmit engines beside the register block
// Assumes: same clock as the bus
// Notes: slow stretches the pending and active windows
`timescale 1ns/100ps
module cpb_can_engine (
    input wire          hclk,
    input wire          hresetn,
    input wire [5:0]    send_request,
    input wire [7:0]    tx_rd_data,
    output logic        rx_load,
    output logic [2:0]  rx_buf_sel,
    output logic [7:0]  rx_std_id_high,
    output logic [7:0]  rx_std_id_low,
    output logic [7:0]  rx_ext_id_high,
    output logic [7:0]  rx_ext_id_low,
    output logic [3:0]  rx_length_code,
    output logic        rx_remote_request,
    output logic [63:0] rx_payload,
    output logic [5:0]  tx_active,
    output logic [5:0]  tx_done,
    output logic [2:0]  tx_rd_buf,
    output logic [3:0]  tx_rd_idx
);
    logic [103:0] f = '0;
    logic         slow = 1'b0;
    logic [7:0]   last_len = 8'h00;
    int           n;
    assign {rx_buf_sel, rx_std_id_high, rx_std_id_low, rx_ext_id_high, rx_ext_id_low,
            rx_length_code, rx_remote_request, rx_payload} = f;
    task automatic rx_frame(input logic [103:0] v);
        @(posedge hclk);
        f <= v;
        rx_load <= 1'b1;
        @(posedge hclk);
        rx_load <= 1'b0;
        f <= ~v;
    endtask
    initial begin
        rx_load = 1'b0;
        tx_active = '0;
        tx_done = '0;
        tx_rd_buf = '0;
        tx_rd_idx = '0;
        forever begin
            @(negedge hclk);
            if (hresetn && |send_request) begin
                n = $clog2(send_request & (~send_request + 6'd1));
                @(posedge hclk);
                repeat (slow ? 12 : 1) @(posedge hclk);
                tx_active[n] <= 1'b1;
                tx_rd_buf <= 3'(n);
                tx_rd_idx <= 4'h4;
                repeat (2) @(posedge hclk);
                last_len <= tx_rd_data;
                repeat (slow ? 10 : 1) @(posedge hclk);
                tx_active[n] <= 1'b0;
                tx_done[n] <= 1'b1;
                @(posedge hclk);
                tx_done[n] <= 1'b0;
            end
        end
    end
endmodule // cpb_can_engine

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the buffer/filter registers
// Assumes: AHB-Lite single word transfers
// Notes: random contents from a fixed seed
`timescale 1ns/100ps
module tb;
    logic        hclk, hresetn, hsel, hwrite;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, rd;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, rx_load, rx_remote_request, mode_enhanced;
    wire  [2:0]  rx_buf_sel, tx_rd_buf;
    wire  [7:0]  rx_std_id_high, rx_std_id_low, rx_ext_id_high, rx_ext_id_low, tx_rd_data;
    wire  [3:0]  rx_length_code, tx_rd_idx;
    wire  [63:0] rx_payload;
    wire  [5:0]  rx_buf_open, tx_active, tx_done, send_request, send_remote_request;
    wire  [5:0]  buffer_extended_frame;
    wire  [15:0] filter_extended_only;
    logic [7:0]  bx[6][13], fx[16][4];
    logic [63:0] pv;
    int          n_fail = 0, num_checks = 0;
    cpb_buffer_filter_regs uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_load, .rx_buf_sel,
        .rx_std_id_high, .rx_std_id_low, .rx_ext_id_high, .rx_ext_id_low, .rx_length_code,
        .rx_remote_request, .rx_payload, .rx_buf_open, .tx_active, .tx_done, .tx_rd_buf,
        .tx_rd_idx, .tx_rd_data, .send_request, .send_remote_request, .buffer_extended_frame,
        .filter_extended_only, .mode_enhanced);
    cpb_can_engine eng (.hclk, .hresetn, .send_request, .tx_rd_data, .rx_load, .rx_buf_sel,
        .rx_std_id_high, .rx_std_id_low, .rx_ext_id_high, .rx_ext_id_low, .rx_length_code,
        .rx_remote_request, .rx_payload, .tx_active, .tx_done, .tx_rd_buf, .tx_rd_idx);
    function automatic logic [11:0] ba(input int n, k);
        return 12'(n * 64 + k * 4);
    endfunction
    function automatic logic [11:0] fa(input int f, j);
        return 12'(512 + f * 16 + j * 4);
    endfunction
    // unimplemented bits read zero: id low byte and length byte
    function automatic logic [7:0] bm(input int k);
        return k == 1 ? 8'heb : k == 4 ? 8'h4f : 8'hff;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input string s, input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(s, e, rd);
    endtask
    task automatic txw(input int n);
        wr(12'h30c, 32'h1 << n);
        wr(ba(n, 2), ~bx[n][2]);
        rc("locked", ba(n, 2), bx[n][2]);
        do @(negedge hclk); while (send_request[n] !== 1'b0);
        @(posedge hclk);
        chk("txlen", bx[n][4] & 8'h4f, eng.last_len);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = '0;
        htrans = '0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        void'($urandom(32'h81bc));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 6; i++) rc("ctrl", 12'h300 + 12'(4 * i), 32'h0);
        $display("test reset done");
        wr(fa(3, 1), 32'hff);
        rc("flt low", fa(3, 1), 32'heb);
        wr(fa(9, 0), 32'h77);
        rc("flt9 legacy", fa(9, 0), 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(12'h304, m);
            #1 chk("enh", m == 1 || m == 2, mode_enhanced);
        end
        rc("buf legacy", ba(2, 5), 32'h0);
        wr(12'h304, 32'h1);
        wr(12'h300, 32'hff);
        rc("dir", 12'h300, 32'hfc);
        $display("test modes done");
        for (int n = 0; n < 6; n++) for (int k = 0; k < 13; k++) begin
            bx[n][k] = 8'($urandom);
            wr(ba(n, k), {24'($urandom), bx[n][k]});
        end
        for (int n = 0; n < 6; n++) begin
            for (int k = 0; k < 13; k++) rc("buf", ba(n, k), bx[n][k] & bm(k));
            chk("rtr", bx[n][4][6], send_remote_request[n]);
            chk("extf", bx[n][1][3], buffer_extended_frame[n]);
        end
        for (int f = 0; f < 16; f++) for (int j = 0; j < 4; j++) begin
            fx[f][j] = 8'($urandom);
            wr(fa(f, j), {24'($urandom), fx[f][j]});
        end
        for (int f = 0; f < 16; f++) begin
            for (int j = 0; j < 4; j++) rc("flt", fa(f, j), fx[f][j] & bm(j));
            chk("exonly", fx[f][1][3], filter_extended_only[f]);
        end
        $display("test storage done");
        eng.slow = 1'b1;
        txw(1);
        eng.slow = 1'b0;
        txw(5);
        wr(ba(1, 2), 32'h3c);
        rc("unlock", ba(1, 2), 32'h3c);
        $display("test send done");
        wr(12'h300, 32'hf8);
        #1 chk("open", 1, rx_buf_open[0]);
        pv = {$urandom, $urandom};
        eng.rx_frame({3'd0, 32'h11223344, 4'h8, 1'b1, pv});
        #1 chk("closed", 0, rx_buf_open[0]);
        rc("rxlen", ba(0, 4), 32'h48);
        rc("rxext", ba(0, 2), 32'h33);
        for (int m = 0; m < 8; m++) rc("rxd", ba(0, 5 + m), pv[8 * m +: 8]);
        wr(ba(0, 5), ~pv[31:0]);
        rc("rx ro", ba(0, 5), pv[7:0]);
        eng.rx_frame({3'd0, 32'h0, 4'h1, 1'b0, ~pv});
        rc("kept", ba(0, 4), 32'h48);
        wr(12'h30c, 32'h1);
        #1 chk("rx send", 0, send_request[0]);
        rc("full", 12'h308, 32'h1);
        wr(12'h308, 32'h1);
        #1 chk("reopen", 1, rx_buf_open[0]);
        $display("test receive done");
        conclude();
    end
endmodule // tb
